/* File: rtl/sup_pkg.sv */
package sup_pkg;

	// ----------------------------------------
	// link timing
	// ----------------------------------------
	localparam int CORE_PERIOD_PS = 10000;
	localparam int MII10_PERIOD_PS = 400000;
	localparam int MII100_PERIOD_PS = 40000;
	localparam int GIG_PERIOD_PS = 8000;
	localparam int RMII_PERIOD_PS = 20000;

	// half period in core cycles, rounded down, never below one
	function automatic int half_cycles(input int period_ps);
		int c;
		c = period_ps / 2 / CORE_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam logic [4:0] HALF_MII10 = 5'(half_cycles(MII10_PERIOD_PS));
	localparam logic [4:0] HALF_MII100 = 5'(half_cycles(MII100_PERIOD_PS));
	localparam logic [4:0] HALF_GIG = 5'(half_cycles(GIG_PERIOD_PS));
	localparam logic [4:0] HALF_RMII = 5'(half_cycles(RMII_PERIOD_PS));

	// each dibit is repeated on ten reference edges at 10 Mb/s
	localparam logic [3:0] RMII_REP_LAST = 4'h9;

	localparam logic ROLE_STRAP_MAC = 1'b1;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {
		SUP_MODE_NIBBLE = 2'b00,
		SUP_MODE_BYTE = 2'b01,
		SUP_MODE_REDUCED = 2'b10,
		SUP_MODE_RMII = 2'b11
	} sup_mode_t;

	typedef enum logic [1:0] {
		SUP_SPD_10 = 2'b00,
		SUP_SPD_100 = 2'b01,
		SUP_SPD_1000 = 2'b10
	} sup_speed_t;

	typedef enum logic {
		SUP_OUT_IDLE = 1'b0,
		SUP_OUT_SEND = 1'b1
	} sup_out_state_t;

	typedef struct packed {
		logic err;
		logic [7:0] data;
	} sup_byte_t;

	typedef struct packed {
		sup_mode_t mode;
		sup_speed_t speed;
		logic full_duplex;
		logic rmii_clk_internal;
	} sup_cfg_t;

	localparam sup_cfg_t CFG_RESET = '{
		mode: SUP_MODE_NIBBLE,
		speed: SUP_SPD_100,
		full_duplex: 1'b1,
		rmii_clk_internal: 1'b0
	};

endpackage

/* File: rtl/sup_sync2.sv */
`timescale 1ns/1ps

// two-stage synchroniser; data flops only, no reset needed
module sup_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge clk_in) begin
		meta_q <= d_in;
		sync_q <= meta_q;
	end

	assign q_out = sync_q;

endmodule

/* File: rtl/sup_uplink_port.sv */
`timescale 1ns/1ps

// Functional notes
// - reduced gigabit link runs at 125 MHz, data on both clock edges; the outbound clock generated here at gigabit is 50 MHz
// - reduced mode: four data lines, control multiplexed on the valid line
// - two-bit mode supports only 10 and 100 Mb/s
// - two-bit mode shares a 50 MHz reference, driven out or taken in
// - two-bit mode moves two bits per clock each direction
// - strap pin level selects MAC role or PHY role
// - nibble PHY role: tx pins are inputs, clocks and status are driven
// - nibble MAC role: rx pins carry our frames, clocks and status are inputs
// - nibble mode moves four bits per clock each direction
// - each direction carries a valid qualifier and an error indicator
// - nibble half duplex: collision asserted when frames overlap
// - byte mode runs at gigabit and full duplex only
// - byte mode moves eight bits per clock each direction
// - byte PHY role: tx clock, valid, error, data are inputs
// - byte MAC role: gigabit rx clock and rx pins are driven to the PHY
// - at 10/100 half duplex, collision is signalled during transmission
// - nibble clock 2.5 or 25 MHz, byte clock 125 MHz; the byte clock generated here is 50 MHz
module sup_uplink_port (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire sup_pkg::sup_cfg_t cfg_in,
	input wire logic mac_phy_role_strap_in,
	input wire logic uplink_tx_valid_pin_in,
	input wire logic uplink_tx_error_pin_in,
	input wire logic [7:0] uplink_tx_data_pins_in,
	input wire logic uplink_tx_clock_pin_in,
	output logic uplink_tx_clock_pin_out,
	output logic uplink_tx_clock_pin_oe_n_out,
	input wire logic uplink_gig_tx_clock_pin_in,
	input wire logic uplink_rx_clock_pin_in,
	output logic uplink_rx_clock_pin_out,
	output logic uplink_rx_clock_pin_oe_n_out,
	output logic uplink_gig_rx_clock_pin_out,
	input wire logic uplink_collision_pin_in,
	output logic uplink_collision_pin_out,
	output logic uplink_collision_pin_oe_n_out,
	input wire logic uplink_carrier_pin_in,
	output logic uplink_carrier_pin_out,
	output logic uplink_carrier_pin_oe_n_out,
	output logic uplink_rx_valid_pin_out,
	output logic uplink_rx_error_pin_out,
	output logic [7:0] uplink_rx_data_pins_out,
	input wire logic out_valid_in,
	input wire sup_pkg::sup_byte_t out_byte_in,
	output logic out_taken_out,
	output sup_pkg::sup_byte_t in_byte_out,
	output logic in_byte_strobe_out,
	output logic in_frame_out,
	output logic role_mac_out,
	output logic cfg_error_out,
	output logic link_collision_out,
	output logic link_carrier_out
);

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	localparam int SW = 16 + $bits(sup_pkg::sup_cfg_t);
	logic [SW-1:0] raw_w;
	logic [SW-1:0] syn_w;
	sup_pkg::sup_cfg_t cfg_s;
	logic strap_s, txc_s, gtxc_s, rxc_s, col_s, crs_s, txv_s, txe_s;
	logic [7:0] txd_s;

	assign raw_w = {cfg_in, mac_phy_role_strap_in, uplink_tx_clock_pin_in, uplink_gig_tx_clock_pin_in,
		uplink_rx_clock_pin_in, uplink_collision_pin_in, uplink_carrier_pin_in, uplink_tx_valid_pin_in,
		uplink_tx_error_pin_in, uplink_tx_data_pins_in};

	sup_sync2 #(.WIDTH(SW)) u_sync (
		.clk_in(core_clk_in),
		.d_in(raw_w),
		.q_out(syn_w)
	);

	assign {cfg_s, strap_s, txc_s, gtxc_s, rxc_s, col_s, crs_s, txv_s, txe_s, txd_s} = syn_w;

	// ----------------------------------------
	// role strap and configuration
	// ----------------------------------------
	logic role_mac_q, strap_taken_q, cfg_err_q;
	sup_pkg::sup_cfg_t cfg_q;

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			strap_taken_q <= 1'b0;
			role_mac_q <= 1'b0;
		end else if (!strap_taken_q) begin
			strap_taken_q <= 1'b1;
			role_mac_q <= (strap_s == sup_pkg::ROLE_STRAP_MAC);
		end
	end

	logic m_nib, m_byte, m_red, m_rmii, gig, slow, half_dup, cfg_bad, cfg_chg, run;

	assign m_nib = (cfg_q.mode == sup_pkg::SUP_MODE_NIBBLE);
	assign m_byte = (cfg_q.mode == sup_pkg::SUP_MODE_BYTE);
	assign m_red = (cfg_q.mode == sup_pkg::SUP_MODE_REDUCED);
	assign m_rmii = (cfg_q.mode == sup_pkg::SUP_MODE_RMII);
	assign gig = (cfg_q.speed == sup_pkg::SUP_SPD_1000);
	assign slow = m_rmii && (cfg_q.speed == sup_pkg::SUP_SPD_10);
	assign half_dup = !cfg_q.full_duplex && !gig;
	assign cfg_bad = (m_rmii && gig)
		|| (m_byte && (!gig || !cfg_q.full_duplex))
		|| (m_nib && gig)
		|| (cfg_q.speed == 2'b11);
	assign cfg_chg = (cfg_s != cfg_q);
	assign run = strap_taken_q && !cfg_err_q;

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			cfg_q <= sup_pkg::CFG_RESET;
			cfg_err_q <= 1'b0;
		end else begin
			cfg_q <= cfg_s;
			cfg_err_q <= cfg_bad;
		end
	end

	// ----------------------------------------
	// link clock generator
	// ----------------------------------------
	logic [4:0] half_cnt, div_cnt_q;
	logic gen_clk_q, gen_d1_q, gen_d2_q;

	always_comb begin
		case (cfg_q.mode)
			sup_pkg::SUP_MODE_RMII: half_cnt = sup_pkg::HALF_RMII;
			sup_pkg::SUP_MODE_BYTE: half_cnt = sup_pkg::HALF_GIG;
			sup_pkg::SUP_MODE_REDUCED: half_cnt = gig ? sup_pkg::HALF_GIG : sup_pkg::HALF_MII100;
			default: half_cnt = (cfg_q.speed == sup_pkg::SUP_SPD_10) ? sup_pkg::HALF_MII10 : sup_pkg::HALF_MII100;
		endcase
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || cfg_chg) begin
			div_cnt_q <= 5'h00;
			gen_clk_q <= 1'b0;
		end else if (div_cnt_q >= half_cnt - 5'h01) begin
			div_cnt_q <= 5'h00;
			gen_clk_q <= ~gen_clk_q;
		end else begin
			div_cnt_q <= div_cnt_q + 5'h01;
		end
	end

	// delayed copy lines our own clock up with what the partner sees through the pin synchronisers
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			gen_d1_q <= 1'b0;
			gen_d2_q <= 1'b0;
		end else begin
			gen_d1_q <= gen_clk_q;
			gen_d2_q <= gen_d1_q;
		end
	end

	// ----------------------------------------
	// clock selection and edges
	// ----------------------------------------
	logic in_ext, out_ext, in_lvl, out_lvl, in_prev_q, out_prev_q;
	logic in_rise, in_fall, out_rise, out_fall;

	assign in_ext = (m_nib && role_mac_q) || m_byte || m_red || (m_rmii && !cfg_q.rmii_clk_internal);
	assign out_ext = (m_nib && role_mac_q) || (m_rmii && !cfg_q.rmii_clk_internal);
	assign in_lvl = !in_ext ? gen_d2_q : ((m_byte || m_red) ? gtxc_s : txc_s);
	assign out_lvl = !out_ext ? gen_clk_q : (m_rmii ? txc_s : rxc_s);

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			in_prev_q <= 1'b0;
			out_prev_q <= 1'b0;
		end else begin
			in_prev_q <= in_lvl;
			out_prev_q <= out_lvl;
		end
	end

	assign in_rise = in_lvl && !in_prev_q;
	assign in_fall = !in_lvl && in_prev_q;
	assign out_rise = out_lvl && !out_prev_q;
	assign out_fall = !out_lvl && out_prev_q;

	logic [3:0] in_rep_q, out_rep_q;

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			in_rep_q <= 4'h0;
			out_rep_q <= 4'h0;
		end else begin
			if (in_rise) begin
				in_rep_q <= (slow && in_rep_q != sup_pkg::RMII_REP_LAST) ? in_rep_q + 4'h1 : 4'h0;
			end
			if (out_fall) begin
				out_rep_q <= (slow && out_rep_q != sup_pkg::RMII_REP_LAST) ? out_rep_q + 4'h1 : 4'h0;
			end
		end
	end

	// ----------------------------------------
	// inbound path: tx pins to user
	// ----------------------------------------
	logic [1:0] last_slot, islot_q;
	logic [7:0] asm_q, asm_next;
	logic in_take, in_err_bit, in_err_q, ctl_rise_q, in_frame_q, in_strobe_q;
	sup_pkg::sup_byte_t in_byte_q;

	assign last_slot = m_rmii ? 2'h3 : (m_byte ? 2'h0 : 2'h1);
	assign in_take = in_rise && (!slow || in_rep_q == 4'h0);
	assign in_err_bit = m_nib && txe_s;
	assign asm_next = m_rmii ? {txd_s[1:0], asm_q[7:2]} : {txd_s[3:0], asm_q[7:4]};

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || !run) begin
			in_frame_q <= 1'b0;
			in_strobe_q <= 1'b0;
			in_byte_q <= '0;
			asm_q <= 8'h00;
			islot_q <= 2'h0;
			in_err_q <= 1'b0;
			ctl_rise_q <= 1'b0;
		end else begin
			in_strobe_q <= 1'b0;
			case (cfg_q.mode)
				sup_pkg::SUP_MODE_BYTE: begin
					if (in_rise) begin
						in_frame_q <= txv_s;
						if (txv_s) begin
							in_byte_q <= '{err: txe_s, data: txd_s};
							in_strobe_q <= 1'b1;
						end
					end
				end
				sup_pkg::SUP_MODE_REDUCED: begin
					if (in_rise) begin
						asm_q <= {4'h0, txd_s[3:0]};
						ctl_rise_q <= txv_s;
					end
					if (in_fall) begin
						in_frame_q <= ctl_rise_q;
						if (ctl_rise_q) begin
							in_byte_q <= '{err: ctl_rise_q ^ txv_s, data: {txd_s[3:0], asm_q[3:0]}};
							in_strobe_q <= 1'b1;
						end
					end
				end
				default: begin
					if (in_take) begin
						in_frame_q <= txv_s;
						if (!txv_s) begin
							islot_q <= 2'h0;
							in_err_q <= 1'b0;
						end else if (islot_q == last_slot) begin
							in_byte_q <= '{err: in_err_q | in_err_bit, data: asm_next};
							in_strobe_q <= 1'b1;
							islot_q <= 2'h0;
							in_err_q <= 1'b0;
						end else begin
							asm_q <= asm_next;
							islot_q <= islot_q + 2'h1;
							in_err_q <= in_err_q | in_err_bit;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// outbound path: user to rx pins
	// ----------------------------------------
	function automatic logic [7:0] piece(input logic [7:0] b, input sup_pkg::sup_mode_t m);
		case (m)
			sup_pkg::SUP_MODE_BYTE: piece = b;
			sup_pkg::SUP_MODE_RMII: piece = {6'h00, b[1:0]};
			default: piece = {4'h0, b[3:0]};
		endcase
	endfunction

	function automatic logic [7:0] rest(input logic [7:0] b, input sup_pkg::sup_mode_t m);
		case (m)
			sup_pkg::SUP_MODE_BYTE: rest = 8'h00;
			sup_pkg::SUP_MODE_RMII: rest = {2'h0, b[7:2]};
			default: rest = {4'h0, b[7:4]};
		endcase
	endfunction

	sup_pkg::sup_out_state_t out_st_q;
	logic [1:0] oslot_q;
	logic [7:0] sh_q, rxd_q;
	logic oerr_q, rxv_q, rxe_q, taken_q, launch;

	assign launch = m_red ? ((oslot_q == 2'h0) ? out_fall : out_rise)
		: (out_fall && (!slow || out_rep_q == 4'h0));

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || !run) begin
			out_st_q <= sup_pkg::SUP_OUT_IDLE;
			oslot_q <= 2'h0;
			sh_q <= 8'h00;
			oerr_q <= 1'b0;
			rxv_q <= 1'b0;
			rxe_q <= 1'b0;
			rxd_q <= 8'h00;
			taken_q <= 1'b0;
		end else begin
			taken_q <= 1'b0;
			if (launch && oslot_q == 2'h0) begin
				if (out_valid_in) begin
					out_st_q <= sup_pkg::SUP_OUT_SEND;
					taken_q <= 1'b1;
					oerr_q <= out_byte_in.err;
					rxv_q <= 1'b1;
					rxe_q <= out_byte_in.err && !m_red;
					rxd_q <= piece(out_byte_in.data, cfg_q.mode);
					sh_q <= rest(out_byte_in.data, cfg_q.mode);
					oslot_q <= (last_slot == 2'h0) ? 2'h0 : 2'h1;
				end else begin
					out_st_q <= sup_pkg::SUP_OUT_IDLE;
					rxv_q <= 1'b0;
					rxe_q <= 1'b0;
					rxd_q <= 8'h00;
				end
			end else if (launch) begin
				rxd_q <= piece(sh_q, cfg_q.mode);
				sh_q <= rest(sh_q, cfg_q.mode);
				oslot_q <= (oslot_q == last_slot) ? 2'h0 : oslot_q + 2'h1;
				if (m_red) begin
					rxv_q <= !oerr_q;
				end
			end
		end
	end

	// ----------------------------------------
	// pin directions, collision and carrier
	// ----------------------------------------
	logic phy_sense, txc_oe_n_q, rxc_oe_n_q, sense_oe_n_q, col_q, crs_q, lcol_q, lcrs_q, sending;

	// no two-way pin is driven until the strap has told us which side we are on
	assign phy_sense = strap_taken_q && !role_mac_q && (m_nib || m_byte);
	assign sending = (out_st_q == sup_pkg::SUP_OUT_SEND);

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			txc_oe_n_q <= 1'b1;
			rxc_oe_n_q <= 1'b1;
			sense_oe_n_q <= 1'b1;
		end else begin
			txc_oe_n_q <= !(strap_taken_q && m_nib && !role_mac_q);
			rxc_oe_n_q <= !(strap_taken_q && ((m_nib && !role_mac_q) || (m_rmii && cfg_q.rmii_clk_internal)));
			sense_oe_n_q <= !phy_sense;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			col_q <= 1'b0;
			crs_q <= 1'b0;
			lcol_q <= 1'b0;
			lcrs_q <= 1'b0;
		end else begin
			col_q <= phy_sense && half_dup && in_frame_q && sending;
			crs_q <= phy_sense && (sending || (half_dup && in_frame_q));
			lcol_q <= role_mac_q && (m_nib || m_byte) && col_s;
			lcrs_q <= role_mac_q && (m_nib || m_byte) && crs_s;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign uplink_tx_clock_pin_out = gen_clk_q;
	assign uplink_rx_clock_pin_out = gen_clk_q;
	assign uplink_gig_rx_clock_pin_out = gen_clk_q;
	assign uplink_tx_clock_pin_oe_n_out = txc_oe_n_q;
	assign uplink_rx_clock_pin_oe_n_out = rxc_oe_n_q;
	assign uplink_collision_pin_out = col_q;
	assign uplink_collision_pin_oe_n_out = sense_oe_n_q;
	assign uplink_carrier_pin_out = crs_q;
	assign uplink_carrier_pin_oe_n_out = sense_oe_n_q;
	assign uplink_rx_valid_pin_out = rxv_q;
	assign uplink_rx_error_pin_out = rxe_q;
	assign uplink_rx_data_pins_out = rxd_q;
	assign out_taken_out = taken_q;
	assign in_byte_out = in_byte_q;
	assign in_byte_strobe_out = in_strobe_q;
	assign in_frame_out = in_frame_q;
	assign role_mac_out = role_mac_q;
	assign cfg_error_out = cfg_err_q;
	assign link_collision_out = lcol_q;
	assign link_carrier_out = lcrs_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_role_strap_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		$past(strap_taken_q) |-> $stable(role_mac_q))
		else $error("role changed after strap capture");

	a_bad_cfg_idle: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		cfg_err_q |=> !in_byte_strobe_out && !uplink_rx_valid_pin_out && !out_taken_out)
		else $error("traffic moved under an illegal configuration");

	a_gig_no_col: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		gig |=> !uplink_collision_pin_out)
		else $error("collision driven at gigabit");

	a_col_overlap: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(phy_sense && half_dup && in_frame_q && sending) |=> uplink_collision_pin_out)
		else $error("overlap without collision");

	a_clk_half_25: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		($changed(gen_clk_q) && m_nib && cfg_q.speed == sup_pkg::SUP_SPD_100 && !cfg_chg) ##1 !cfg_chg
		|-> $stable(gen_clk_q) ##1 $changed(gen_clk_q))
		else $error("nibble clock half period wrong");

	a_phy_clk_drive: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(strap_taken_q && !role_mac_q && m_nib) |=> !uplink_tx_clock_pin_oe_n_out && !uplink_rx_clock_pin_oe_n_out
		&& !uplink_collision_pin_oe_n_out)
		else $error("phy role not driving clocks");

	a_mac_clk_input: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(role_mac_q && m_nib) |=> uplink_tx_clock_pin_oe_n_out && uplink_rx_clock_pin_oe_n_out
		&& uplink_carrier_pin_oe_n_out)
		else $error("mac role driving partner pins");

	a_rmii_ref_dir: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		m_rmii |=> (uplink_rx_clock_pin_oe_n_out == !$past(cfg_q.rmii_clk_internal))
		&& uplink_tx_clock_pin_oe_n_out)
		else $error("reference clock direction wrong");

	a_byte_capture: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
		(run && m_byte && in_rise && txv_s) |=> in_byte_strobe_out && in_byte_out.data == $past(txd_s))
		else $error("byte not captured on its edge");

endmodule

/* File: tb/sup_link_partner.sv */
`timescale 1ns/1ps

module sup_link_partner (
	input wire logic in_clk_in,
	input wire logic out_clk_in,
	input wire logic [3:0] width_in,
	output logic valid_out,
	output logic err_out,
	output logic [7:0] data_out,
	input wire logic rx_valid_in,
	input wire logic [7:0] rx_data_in
);
	// ----------------------------------------
	// frame source
	// ----------------------------------------
	logic [7:0] got_q[$];
	logic [7:0] acc;
	int pos = 0;
	initial begin
		valid_out = 1'b0;
		err_out = 1'b0;
		data_out = 8'h5A;
	end
	// launch on the falling edge so lines are steady at the sampling rise
	task automatic send_frame(input logic [7:0] bytes[$], input int err_idx);
		for (int i = 0; i < bytes.size(); i++) begin
			for (int k = 0; k < 8; k += int'(width_in)) begin
				@(negedge in_clk_in);
				valid_out <= 1'b1;
				err_out <= (i == err_idx) && (k == 0);
				data_out <= (bytes[i] >> k) & ((8'h01 << width_in) - 8'h01);
			end
		end
		@(negedge in_clk_in);
		valid_out <= 1'b0;
		err_out <= 1'b0;
		// idle lines never repeat the last piece
		data_out <= ~data_out;
	endtask
	// ----------------------------------------
	// frame sink
	// ----------------------------------------
	// receive-error pin is left unused on this side
	// sampled on the falling edge, before the design's launch on that same edge reaches the pins
	always @(negedge out_clk_in) begin
		if (rx_valid_in === 1'b1) begin
			acc = (acc >> width_in) | (rx_data_in << (4'h8 - width_in));
			pos = pos + int'(width_in);
			if (pos >= 8) begin
				got_q.push_back(acc);
				pos = 0;
			end
		end else begin
			pos = 0;
		end
	end
endmodule

/* File: tb/test_sup_uplink_port.sv */
`timescale 1ns/1ps

module test_sup_uplink_port;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic core_clk_in, rst_n_in, mac_phy_role_strap_in, out_valid_in, link_clk, link_on, col_drv, crs_drv;
	logic uplink_tx_valid_pin_in, uplink_tx_error_pin_in, out_taken_out, in_byte_strobe_out, in_frame_out;
	logic [7:0] uplink_tx_data_pins_in, uplink_rx_data_pins_out;
	logic uplink_tx_clock_pin_out, uplink_tx_clock_pin_oe_n_out, uplink_rx_clock_pin_out;
	logic uplink_rx_clock_pin_oe_n_out, uplink_gig_rx_clock_pin_out, uplink_collision_pin_out;
	logic uplink_collision_pin_oe_n_out, uplink_carrier_pin_out, uplink_carrier_pin_oe_n_out;
	logic uplink_rx_valid_pin_out, uplink_rx_error_pin_out, role_mac_out, cfg_error_out;
	logic link_collision_out, link_carrier_out, tx_clk_w, rx_clk_w, col_w, crs_w, p_in_clk, p_out_clk;
	logic [1:0] sel;
	logic [3:0] width, oe_w;
	sup_pkg::sup_cfg_t cfg_in;
	sup_pkg::sup_byte_t out_byte_in, in_byte_out;
	int mismatches = 0;
	int comparisons = 0;
	int cycles = 0;
	int rxe_cycles = 0;
	logic [8:0] got_in[$];
	// two-way pins resolve from the design's enable and the bench's drive
	assign tx_clk_w = (uplink_tx_clock_pin_oe_n_out === 1'b0) ? uplink_tx_clock_pin_out : link_clk;
	assign rx_clk_w = (uplink_rx_clock_pin_oe_n_out === 1'b0) ? uplink_rx_clock_pin_out : link_clk;
	assign col_w = (uplink_collision_pin_oe_n_out === 1'b0) ? uplink_collision_pin_out : col_drv;
	assign crs_w = (uplink_carrier_pin_oe_n_out === 1'b0) ? uplink_carrier_pin_out : crs_drv;
	assign p_in_clk = (sel == 2'd2) ? link_clk : (sel == 2'd3) ? rx_clk_w : tx_clk_w;
	assign p_out_clk = (sel == 2'd2) ? uplink_gig_rx_clock_pin_out : rx_clk_w;
	assign oe_w = {uplink_tx_clock_pin_oe_n_out, uplink_rx_clock_pin_oe_n_out, uplink_collision_pin_oe_n_out,
		uplink_carrier_pin_oe_n_out};
	assign width = (cfg_in.mode == sup_pkg::SUP_MODE_BYTE) ? 4'h8
		: (cfg_in.mode == sup_pkg::SUP_MODE_RMII) ? 4'h2 : 4'h4;
	sup_uplink_port sup_uplink_port_i (
		.core_clk_in, .rst_n_in, .cfg_in, .mac_phy_role_strap_in,
		.uplink_tx_valid_pin_in, .uplink_tx_error_pin_in, .uplink_tx_data_pins_in,
		.uplink_tx_clock_pin_in(tx_clk_w), .uplink_tx_clock_pin_out, .uplink_tx_clock_pin_oe_n_out,
		.uplink_gig_tx_clock_pin_in(link_clk), .uplink_rx_clock_pin_in(rx_clk_w), .uplink_rx_clock_pin_out,
		.uplink_rx_clock_pin_oe_n_out, .uplink_gig_rx_clock_pin_out, .uplink_collision_pin_in(col_w),
		.uplink_collision_pin_out, .uplink_collision_pin_oe_n_out, .uplink_carrier_pin_in(crs_w),
		.uplink_carrier_pin_out, .uplink_carrier_pin_oe_n_out, .uplink_rx_valid_pin_out, .uplink_rx_error_pin_out,
		.uplink_rx_data_pins_out, .out_valid_in, .out_byte_in, .out_taken_out, .in_byte_out, .in_byte_strobe_out,
		.in_frame_out, .role_mac_out, .cfg_error_out, .link_collision_out, .link_carrier_out
	);
	sup_link_partner sup_link_partner_i (
		.in_clk_in(p_in_clk), .out_clk_in(p_out_clk), .width_in(width),
		.valid_out(uplink_tx_valid_pin_in), .err_out(uplink_tx_error_pin_in), .data_out(uplink_tx_data_pins_in),
		.rx_valid_in(uplink_rx_valid_pin_out), .rx_data_in(uplink_rx_data_pins_out)
	);
	// ----------------------------------------
	// clocks, capture, limits
	// ----------------------------------------
	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end
	// link clock stands still while no scenario asks for it
	initial begin
		link_clk = 1'b0;
		#7;
		forever #40 link_clk = link_on ? ~link_clk : 1'b0;
	end
	always @(negedge core_clk_in) if (in_byte_strobe_out === 1'b1) got_in.push_back(in_byte_out);
	always @(negedge core_clk_in) if (uplink_rx_error_pin_out === 1'b1) rxe_cycles++;
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			$display("wrong value run length: expected below 30000, seen 30000");
			report_and_stop();
		end
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	function automatic sup_pkg::sup_cfg_t mk(input sup_pkg::sup_mode_t m, input sup_pkg::sup_speed_t s, input logic fd);
		return '{mode: m, speed: s, full_duplex: fd, rmii_clk_internal: 1'b1};
	endfunction
	task automatic do_reset(input sup_pkg::sup_cfg_t c, input logic strap, input logic [1:0] s);
		@(negedge core_clk_in);
		rst_n_in = 1'b0;
		cfg_in = c;
		mac_phy_role_strap_in = strap;
		sel = s;
		repeat (16) @(negedge core_clk_in);
		check("reset pins", {oe_w, uplink_rx_valid_pin_out}, 5'h1E);
		rst_n_in = 1'b1;
		repeat (6) @(negedge core_clk_in);
	endtask
	task automatic period_of(input logic use_rx, output int p);
		realtime t0;
		if (use_rx) @(posedge rx_clk_w); else @(posedge tx_clk_w);
		t0 = $realtime;
		if (use_rx) @(posedge rx_clk_w); else @(posedge tx_clk_w);
		p = int'($realtime - t0);
	endtask
	task automatic user_send(input logic [7:0] bytes[$]);
		int w;
		foreach (bytes[i]) begin
			out_valid_in = 1'b1;
			out_byte_in = '{err: (i == 1), data: bytes[i]};
			w = 0;
			do begin
				@(negedge core_clk_in);
				w++;
			end while (out_taken_out !== 1'b1 && w < 400);
			check("byte taken", out_taken_out, 1'b1);
		end
		out_valid_in = 1'b0;
	endtask
	task automatic xfer(input int n, input int e);
		logic [7:0] in_b[$];
		logic [7:0] out_b[$];
		int e0;
		got_in.delete();
		e0 = rxe_cycles;
		sup_link_partner_i.got_q.delete();
		for (int i = 0; i < n; i++) begin
			in_b.push_back(8'(8'h1E + i * 37));
			out_b.push_back(8'(8'hC3 ^ (i * 29)));
		end
		fork
			sup_link_partner_i.send_frame(in_b, e);
			user_send(out_b);
		join
		repeat (60) @(negedge core_clk_in);
		check("inbound count", got_in.size(), n);
		check("outbound count", sup_link_partner_i.got_q.size(), n);
		check("outbound error", rxe_cycles != e0, 1'b1);
		for (int i = 0; i < got_in.size() && i < n; i++) check("inbound byte", got_in[i], {i == e, in_b[i]});
		for (int i = 0; i < sup_link_partner_i.got_q.size() && i < n; i++) begin
			check("outbound byte", sup_link_partner_i.got_q[i], out_b[i]);
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_nibble_phy();
		int p;
		do_reset(mk(sup_pkg::SUP_MODE_NIBBLE, sup_pkg::SUP_SPD_100, 1'b1), 1'b0, 2'd0);
		check("role", role_mac_out, 1'b0);
		check("driven pins", oe_w, 4'h0);
		period_of(1'b0, p);
		check("tx clock period", p, 2 * sup_pkg::HALF_MII100 * 10);
		xfer(4, 1);
		do_reset(mk(sup_pkg::SUP_MODE_NIBBLE, sup_pkg::SUP_SPD_10, 1'b1), 1'b0, 2'd0);
		period_of(1'b0, p);
		check("slow tx clock period", p, 2 * sup_pkg::HALF_MII10 * 10);
		do_reset(mk(sup_pkg::SUP_MODE_NIBBLE, sup_pkg::SUP_SPD_100, 1'b0), 1'b0, 2'd0);
		fork
			xfer(6, -1);
			begin
				repeat (24) @(negedge core_clk_in);
				check("overlap status", {uplink_collision_pin_out, uplink_carrier_pin_out, in_frame_out}, 3'h7);
			end
		join
		check("collision after", {uplink_collision_pin_out, in_frame_out}, 2'h0);
		$display("test nibble phy finished, %0d mismatches", mismatches);
	endtask
	task automatic t_nibble_mac();
		link_on = 1'b1;
		do_reset(mk(sup_pkg::SUP_MODE_NIBBLE, sup_pkg::SUP_SPD_100, 1'b1), 1'b1, 2'd1);
		check("role", role_mac_out, 1'b1);
		check("released pins", oe_w, 4'hF);
		mac_phy_role_strap_in = 1'b0;
		col_drv = 1'b1;
		repeat (8) @(negedge core_clk_in);
		check("role held", role_mac_out, 1'b1);
		check("status in", {link_collision_out, link_carrier_out}, 2'b10);
		col_drv = 1'b0;
		crs_drv = 1'b1;
		repeat (8) @(negedge core_clk_in);
		check("status in", {link_collision_out, link_carrier_out}, 2'b01);
		crs_drv = 1'b0;
		xfer(4, 2);
		for (int r = 0; r < 2; r++) begin
			do_reset(mk(sup_pkg::SUP_MODE_BYTE, sup_pkg::SUP_SPD_1000, 1'b1), 1'(r), 2'd2);
			check("config accepted", cfg_error_out, 1'b0);
			check("status pins", oe_w[1:0], {2{1'(r)}});
			xfer(5, 3);
		end
		link_on = 1'b0;
		$display("test mac and byte finished, %0d mismatches", mismatches);
	endtask
	task automatic t_rmii_cfg();
		int p;
		logic [5:0] tbl[8];
		do_reset(mk(sup_pkg::SUP_MODE_RMII, sup_pkg::SUP_SPD_100, 1'b1), 1'b0, 2'd3);
		check("reference driven", uplink_rx_clock_pin_oe_n_out, 1'b0);
		period_of(1'b1, p);
		check("reference period", p, 2 * sup_pkg::HALF_RMII * 10);
		xfer(3, -1);
		tbl = '{6'h17, 6'h19, 6'h3B, 6'h0B, 6'h0F, 6'h32, 6'h00, 6'h2A};
		for (int i = 0; i < 8; i++) begin
			do_reset(mk(sup_pkg::sup_mode_t'(tbl[i][5:4]), sup_pkg::sup_speed_t'(tbl[i][3:2]), tbl[i][1]), 1'b0, 2'd0);
			check("config error", cfg_error_out, tbl[i][0]);
		end
		$display("test two-bit and config finished, %0d mismatches", mismatches);
	endtask
	initial begin
		rst_n_in = 1'b0;
		cfg_in = mk(sup_pkg::SUP_MODE_NIBBLE, sup_pkg::SUP_SPD_100, 1'b1);
		mac_phy_role_strap_in = 1'b0;
		out_valid_in = 1'b0;
		out_byte_in = '0;
		link_on = 1'b0;
		col_drv = 1'b0;
		crs_drv = 1'b0;
		sel = 2'd0;
		t_nibble_phy();
		t_nibble_mac();
		t_rmii_cfg();
		report_and_stop();
	end
endmodule
